/* File: mbcfg_defines.svh */
// Offsets, field layouts, reset values and timing counts of the
// configuration and watchdog block. Included by bare name; no logic.
`ifndef MBCFG_DEFINES_SVH
`define MBCFG_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MBCFG_OFS_VERSION  16'h0000
`define MBCFG_OFS_SWITCH   16'h0001
`define MBCFG_OFS_BAUD     16'h0002
`define MBCFG_OFS_FRAMING  16'h0003
`define MBCFG_OFS_PARITY   16'h0004
`define MBCFG_OFS_DELAY    16'h0005
`define MBCFG_OFS_MODE     16'h0006
`define MBCFG_OFS_STATION  16'h0007
`define MBCFG_OFS_TIMEOUT  16'h0008
`define MBCFG_OFS_DEFOUT   16'h000c
`define MBCFG_OFS_OUTPUTS  16'h0033

// ****************************************************************
// Bit spaces: upper twelve address bits, low four pick the output
// ****************************************************************
`define MBCFG_COIL_DEF_BASE 12'h00c
`define MBCFG_COIL_OUT_BASE 12'h033
`define MBCFG_NUM_DISC      16'h0006

// ****************************************************************
// Function codes
// ****************************************************************
`define MBCFG_F_RD_COILS  8'h01
`define MBCFG_F_RD_DISC   8'h02
`define MBCFG_F_RD_INREG  8'h03
`define MBCFG_F_RD_HOLD   8'h04
`define MBCFG_F_WR_COIL   8'h05
`define MBCFG_F_WR_REG    8'h06
`define MBCFG_F_WR_COILS  8'h0f
`define MBCFG_F_WR_REGS   8'h10

// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define MBCFG_RST_BAUD     16'h0003
`define MBCFG_RST_FRAMING  16'h0801
`define MBCFG_RST_PARITY   16'h0000
`define MBCFG_RST_DELAY    16'h0000
`define MBCFG_RST_MODE     16'h0000
`define MBCFG_RST_STATION  16'h0000
`define MBCFG_RST_TIMEOUT  16'h0000
`define MBCFG_RST_DEFOUT   16'h0000
`define MBCFG_STOP_TWO     8'h02
`define MBCFG_DATA_SEVEN   8'h07
`define MBCFG_MODE_ASCII   16'h0001
`define MBCFG_PARITY_MAX   16'h0004
`define MBCFG_SW_ADDR_MAX  16'h001f
`define MBCFG_STATION_MAX  16'h00ff

// ****************************************************************
// Timing
// ****************************************************************
`define MBCFG_CLK_NS        8
`define MBCFG_MS_NS         1000000
`define MBCFG_TICKS_PER_MS  (`MBCFG_MS_NS / `MBCFG_CLK_NS)
`define MBCFG_LED_HOLD_MS   16'd50

`endif

/* File: mbcfg_pkg.sv */
// Types shared by the configuration and watchdog block.
// Assumes nothing of its surroundings.
package mbcfg_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_wait,
    st_send
  } mbcfg_state_t;

endpackage

/* File: mbcfg_ms_timer.sv */
// Millisecond elapsed-time counter, saturating at all ones.
// Assumes clear is synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module mbcfg_ms_timer #(
  parameter int TICKS_PER_MS = 125000
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Control and count
  input  wire logic        clear,
  output logic      [15:0] elapsed
);

  localparam int TW = $clog2(TICKS_PER_MS + 1);

  logic [TW-1:0] tick;
  logic [TW-1:0] next_tick;
  logic [15:0]   next_elapsed;

  always_comb begin
    next_tick    = tick;
    next_elapsed = elapsed;
    if (clear) begin
      next_tick    = '0;
      next_elapsed = 16'h0000;
    end else if (tick == TW'(TICKS_PER_MS - 1)) begin
      next_tick = '0;
      if (elapsed != 16'hffff) begin
        next_elapsed = elapsed + 16'h0001;
      end
    end else begin
      next_tick = tick + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick    <= '0;
      elapsed <= 16'h0000;
    end else begin
      tick    <= next_tick;
      elapsed <= next_elapsed;
    end
  end

endmodule

`default_nettype wire

/* File: mbcfg_core.sv */
// Register bank, station match, reply pacing and watchdog of the
// 16-output expansion module.
// Assumes a frame decoder that delivers checksum-good requests, one
// 16-bit word or one bit per strobe, and a transmitter that pulses
// reply_done once the answer has left the line.
`timescale 1ns/1ps
`default_nettype none
`include "mbcfg_defines.svh"

module mbcfg_core #(
  parameter int          TICKS_PER_MS = `MBCFG_TICKS_PER_MS,
  parameter logic [15:0] VERSION_ID   = 16'h0001 // Arbitrary value
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Switches
  input  wire logic        addr_switch_weight1,
  input  wire logic        addr_switch_weight2,
  input  wire logic        addr_switch_weight4,
  input  wire logic        addr_switch_weight8,
  input  wire logic        addr_switch_weight16,
  input  wire logic        factory_restore_switch,
  // Decoded request
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_station,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  // Reply
  input  wire logic        reply_done,
  output logic             reply_valid,
  output logic             reply_exception,
  output logic      [15:0] reply_data,
  // Applied link settings
  output logic      [19:0] link_baud_rate,
  output logic      [2:0]  link_parity,
  output logic             link_two_stop,
  output logic             link_seven_bits,
  output logic             link_ascii,
  // Outputs and indicators
  output logic      [15:0] out_state,
  output logic      [15:0] out_led,
  output logic             comm_led,
  output logic             restore_active
);

  // ****************************************************************
  // State
  // ****************************************************************
  mbcfg_pkg::mbcfg_state_t state, next_state;
  logic [15:0] cfg_baud, cfg_framing, cfg_parity, cfg_delay, cfg_mode;
  logic [15:0] cfg_station, cfg_timeout, out_default, applied_delay;
  logic [15:0] next_baud, next_framing, next_parity, next_delay, next_mode;
  logic [15:0] next_station, next_timeout, next_default, next_out;
  logic [15:0] next_reply_data, next_applied_delay;
  logic [19:0] next_baud_rate;
  logic [2:0]  next_parity_sel;
  logic        next_two_stop, next_seven, next_ascii, next_reply_valid;
  logic        next_exception, next_comm_led, next_restore, powered;
  logic [15:0] wd_elapsed, dly_elapsed, led_elapsed, rd_hold;
  logic [15:0] sw_word;
  logic [7:0]  sw_addr, station_addr;
  logic [3:0]  bidx;
  logic        accept, apply, wd_fire, wd_clear, hold_hit, hit;
  logic        coil_out, coil_def;

  // ****************************************************************
  // Address and decode helpers
  // ****************************************************************
  assign sw_addr = {3'h0, addr_switch_weight16, addr_switch_weight8,
                    addr_switch_weight4, addr_switch_weight2,
                    addr_switch_weight1};
  assign sw_word = {10'h000, factory_restore_switch, sw_addr[4:0]};
  // Register value of 32 and up overrides the switches
  assign station_addr = (cfg_station > `MBCFG_SW_ADDR_MAX) ?
                        cfg_station[7:0] : sw_addr;
  assign accept   = (state == mbcfg_pkg::st_idle) && req_valid &&
                    (req_station == station_addr);
  assign apply    = (state == mbcfg_pkg::st_send) && reply_done;
  assign wd_fire  = (cfg_timeout != 16'h0000) &&
                    (wd_elapsed >= cfg_timeout);
  assign wd_clear = accept || wd_fire || restore_active;
  assign bidx     = req_addr[3:0];
  assign coil_out = (req_addr[15:4] == `MBCFG_COIL_OUT_BASE);
  assign coil_def = (req_addr[15:4] == `MBCFG_COIL_DEF_BASE);

  // Holding register read map
  always_comb begin
    hold_hit = 1'b1;
    case (req_addr)
      `MBCFG_OFS_BAUD:    rd_hold = cfg_baud;
      `MBCFG_OFS_FRAMING: rd_hold = cfg_framing;
      `MBCFG_OFS_PARITY:  rd_hold = cfg_parity;
      `MBCFG_OFS_DELAY:   rd_hold = cfg_delay;
      `MBCFG_OFS_MODE:    rd_hold = cfg_mode;
      `MBCFG_OFS_STATION: rd_hold = cfg_station;
      `MBCFG_OFS_TIMEOUT: rd_hold = cfg_timeout;
      `MBCFG_OFS_DEFOUT:  rd_hold = out_default;
      `MBCFG_OFS_OUTPUTS: rd_hold = out_state;
      default: begin
        rd_hold  = 16'h0000;
        hold_hit = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Timers
  // ****************************************************************
  mbcfg_ms_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_wd_timer (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (wd_clear),
    .elapsed (wd_elapsed)
  );

  mbcfg_ms_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_dly_timer (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (state == mbcfg_pkg::st_idle),
    .elapsed (dly_elapsed)
  );

  mbcfg_ms_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_led_timer (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (apply),
    .elapsed (led_elapsed)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_state = state;         next_baud = cfg_baud;
    next_framing = cfg_framing; next_parity = cfg_parity;
    next_delay = cfg_delay;     next_mode = cfg_mode;
    next_station = cfg_station; next_timeout = cfg_timeout;
    next_default = out_default; next_out = out_state;
    next_reply_data = reply_data;
    next_exception = reply_exception;
    next_applied_delay = applied_delay;
    next_reply_valid = 1'b0;
    hit = 1'b0;
    if (wd_fire) begin
      next_out = out_default;
    end
    case (state)
      mbcfg_pkg::st_idle: begin
        if (accept) begin
          next_reply_data = 16'h0000;
          case (req_func)
            `MBCFG_F_RD_COILS: begin
              hit = coil_out || coil_def;
              next_reply_data[0] = coil_out ? out_state[bidx] :
                                              out_default[bidx];
            end
            `MBCFG_F_RD_DISC: begin
              hit = (req_addr < `MBCFG_NUM_DISC);
              next_reply_data[0] = sw_word[bidx];
            end
            `MBCFG_F_RD_INREG: begin
              hit = (req_addr == `MBCFG_OFS_VERSION) ||
                    (req_addr == `MBCFG_OFS_SWITCH);
              next_reply_data = req_addr[0] ? sw_word : VERSION_ID;
            end
            `MBCFG_F_RD_HOLD: begin
              hit = hold_hit;
              next_reply_data = rd_hold;
            end
            `MBCFG_F_WR_COIL, `MBCFG_F_WR_COILS: begin
              hit = coil_out || coil_def;
              if (coil_out) next_out[bidx] = req_wdata[0];
              if (coil_def) next_default[bidx] = req_wdata[0];
              next_reply_data = req_wdata;
            end
            `MBCFG_F_WR_REG, `MBCFG_F_WR_REGS: begin
              hit = hold_hit;
              next_reply_data = req_wdata;
              case (req_addr)
                `MBCFG_OFS_BAUD:    next_baud = req_wdata;
                `MBCFG_OFS_FRAMING: next_framing = req_wdata;
                `MBCFG_OFS_PARITY:  next_parity = req_wdata;
                `MBCFG_OFS_DELAY:   next_delay = req_wdata;
                `MBCFG_OFS_MODE:    next_mode = req_wdata;
                `MBCFG_OFS_STATION: begin
                  hit = (req_wdata <= `MBCFG_STATION_MAX);
                  if (hit) next_station = req_wdata;
                end
                `MBCFG_OFS_TIMEOUT: next_timeout = req_wdata;
                `MBCFG_OFS_DEFOUT:  next_default = req_wdata;
                `MBCFG_OFS_OUTPUTS: next_out = req_wdata;
                default: next_out = next_out;
              endcase
            end
            default: hit = 1'b0;
          endcase
          next_exception = !hit;
          next_state = mbcfg_pkg::st_wait;
        end
      end
      mbcfg_pkg::st_wait: begin
        if (dly_elapsed >= applied_delay) begin
          next_reply_valid = 1'b1;
          next_state = mbcfg_pkg::st_send;
        end
      end
      mbcfg_pkg::st_send: begin
        if (reply_done) begin
          next_state = mbcfg_pkg::st_idle;
          next_applied_delay = cfg_delay;
        end
      end
      default: next_state = mbcfg_pkg::st_idle;
    endcase
    // Restore holds every register at its factory value
    if (restore_active) begin
      next_baud = `MBCFG_RST_BAUD;       next_framing = `MBCFG_RST_FRAMING;
      next_parity = `MBCFG_RST_PARITY;   next_delay = `MBCFG_RST_DELAY;
      next_mode = `MBCFG_RST_MODE;       next_station = `MBCFG_RST_STATION;
      next_timeout = `MBCFG_RST_TIMEOUT; next_default = `MBCFG_RST_DEFOUT;
      next_out = `MBCFG_RST_DEFOUT;
      next_applied_delay = `MBCFG_RST_DELAY;
    end
  end

  // Applied link settings, decoded from the stored registers
  always_comb begin
    next_baud_rate  = link_baud_rate;
    next_parity_sel = link_parity;
    next_two_stop   = link_two_stop;
    next_seven      = link_seven_bits;
    next_ascii      = link_ascii;
    if (apply || restore_active) begin
      case (next_baud)
        16'h0000: next_baud_rate = 20'd2400;
        16'h0001: next_baud_rate = 20'd4800;
        16'h0002: next_baud_rate = 20'd9600;
        16'h0003: next_baud_rate = 20'd19200;
        16'h0004: next_baud_rate = 20'd38400;
        16'h0005: next_baud_rate = 20'd57600;
        16'h0006: next_baud_rate = 20'd115200;
        default:  next_baud_rate = 20'({4'h0, next_baud} * 20'd10);
      endcase
      next_parity_sel = (next_parity <= `MBCFG_PARITY_MAX) ?
                        next_parity[2:0] : 3'h0;
      next_two_stop = (next_framing[7:0] == `MBCFG_STOP_TWO);
      next_seven = (next_framing[15:8] == `MBCFG_DATA_SEVEN);
      next_ascii = (next_mode == `MBCFG_MODE_ASCII);
    end
    // Lit while restoring, and for a hold time after each answer
    if (restore_active || apply) begin
      next_comm_led = 1'b1;
    end else if (led_elapsed >= `MBCFG_LED_HOLD_MS) begin
      next_comm_led = 1'b0;
    end else begin
      next_comm_led = comm_led;
    end
    // Switch caught in the first cycle after reset release
    next_restore = powered ? (restore_active && factory_restore_switch) :
                             factory_restore_switch;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= mbcfg_pkg::st_idle;
      cfg_baud <= `MBCFG_RST_BAUD;          cfg_framing <= `MBCFG_RST_FRAMING;
      cfg_parity <= `MBCFG_RST_PARITY;      cfg_delay <= `MBCFG_RST_DELAY;
      cfg_mode <= `MBCFG_RST_MODE;          cfg_station <= `MBCFG_RST_STATION;
      cfg_timeout <= `MBCFG_RST_TIMEOUT;    out_default <= `MBCFG_RST_DEFOUT;
      out_state <= `MBCFG_RST_DEFOUT;       out_led <= `MBCFG_RST_DEFOUT;
      applied_delay <= `MBCFG_RST_DELAY;    reply_data <= 16'h0000;
      reply_valid <= 1'b0;                  reply_exception <= 1'b0;
      link_baud_rate <= 20'd19200;          link_parity <= 3'h0;
      link_two_stop <= 1'b0;                link_seven_bits <= 1'b0;
      link_ascii <= 1'b0;                   comm_led <= 1'b0;
      restore_active <= 1'b0;               powered <= 1'b0;
    end else begin
      state <= next_state;
      cfg_baud <= next_baud;                cfg_framing <= next_framing;
      cfg_parity <= next_parity;            cfg_delay <= next_delay;
      cfg_mode <= next_mode;                cfg_station <= next_station;
      cfg_timeout <= next_timeout;          out_default <= next_default;
      out_state <= next_out;                out_led <= next_out;
      applied_delay <= next_applied_delay;  reply_data <= next_reply_data;
      reply_valid <= next_reply_valid;      reply_exception <= next_exception;
      link_baud_rate <= next_baud_rate;     link_parity <= next_parity_sel;
      link_two_stop <= next_two_stop;       link_seven_bits <= next_seven;
      link_ascii <= next_ascii;             comm_led <= next_comm_led;
      restore_active <= next_restore;       powered <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_accept;
    accept && !restore_active;
  endsequence
  sequence s_reply_out;
    (state == mbcfg_pkg::st_wait) ##1 reply_valid;
  endsequence

  a_switch_address: assert property (
    (cfg_station <= `MBCFG_SW_ADDR_MAX) |-> station_addr == {3'h0,
      addr_switch_weight16, addr_switch_weight8, addr_switch_weight4,
      addr_switch_weight2, addr_switch_weight1})
    else $error("station address not taken from switches");
  a_bus_address: assert property (
    (cfg_station > `MBCFG_SW_ADDR_MAX) |-> station_addr == cfg_station[7:0])
    else $error("configured station address not used");
  a_foreign_request: assert property (
    (state == mbcfg_pkg::st_idle && req_valid &&
     req_station != station_addr) |=> state == mbcfg_pkg::st_idle)
    else $error("request for another station taken");
  a_reply_paced: assert property (
    s_accept |=> (state == mbcfg_pkg::st_wait) ##1
                 (reply_valid == (applied_delay == 16'h0000)))
    else $error("reply not paced by the delay register");
  a_reply_delay_hold: assert property (
    (state == mbcfg_pkg::st_wait && dly_elapsed < applied_delay)
      |=> !reply_valid)
    else $error("reply sent before the delay ran out");
  a_send_after_reply: assert property (
    s_reply_out |-> state == mbcfg_pkg::st_send)
    else $error("reply strobe outside the send phase");
  a_baud_decode: assert property (
    (apply && !restore_active && cfg_baud == 16'h0007)
      |=> link_baud_rate == 20'd70)
    else $error("baud code above six not scaled by ten");
  a_link_apply_late: assert property (
    !$stable(link_ascii) |-> $past(apply) || $past(restore_active))
    else $error("framing mode changed before the reply was sent");
  a_wd_disabled: assert property (
    (cfg_timeout == 16'h0000 && !accept && !restore_active)
      |=> out_state == $past(out_state))
    else $error("watchdog fired while disabled");
  a_wd_force: assert property (
    (wd_fire && !accept && !restore_active)
      |=> out_state == $past(out_default))
    else $error("watchdog did not force default outputs");
  a_restore_clear: assert property (
    restore_active |=> (cfg_timeout == 16'h0000 && out_state == 16'h0000
                        && cfg_station == 16'h0000))
    else $error("restore left register values");
  a_comm_indicator: assert property (
    apply |=> comm_led [*2])
    else $error("communication indicator not lit after answer");
  a_output_led: assert property (
    out_led == out_state)
    else $error("output indicator differs from output");

endmodule

`default_nettype wire

/* File: mbcfg_master.sv */
// Master-side model: issues decoded requests, reports the answer sent.
// Assumes the core under test runs on the same mclk.
`timescale 1ns/1ps
`default_nettype none
module mbcfg_master (
  // Clock
  input  wire logic        mclk,
  // Request side
  output logic             req_valid,
  output logic      [7:0]  req_station,
  output logic      [7:0]  req_func,
  output logic      [15:0] req_addr,
  output logic      [15:0] req_wdata,
  // Reply side
  output logic             reply_done,
  input  wire logic        reply_valid,
  input  wire logic        reply_exception,
  input  wire logic [15:0] reply_data
);
  int          lag = 0;
  int          cyc;
  logic        got;
  logic        exc;
  logic [15:0] rd;
  initial begin
    req_valid = 1'b0;
    reply_done = 1'b0;
    {req_station, req_func, req_addr, req_wdata} = 48'h0;
  end
  // One request; answer marked sent after lag cycles
  task automatic xfer(input logic [47:0] rq);
    got = 1'b0;
    cyc = 0;
    @(posedge mclk) #1;
    {req_station, req_func, req_addr, req_wdata} = rq;
    req_valid = 1'b1;
    @(posedge mclk) #1;
    req_valid = 1'b0;
    {req_station, req_func, req_addr, req_wdata} = ~rq;
    while (!got && cyc < 400) begin
      @(posedge mclk) #1;
      cyc++;
      got = reply_valid;
    end
    exc = reply_exception;
    rd = reply_data;
    if (got) begin
      repeat (lag) @(posedge mclk) #1;
      reply_done = 1'b1;
      @(posedge mclk) #1;
      reply_done = 1'b0;
      @(posedge mclk) #1;
    end
  endtask
endmodule
`default_nettype wire

/* File: mbcfg_core_bench.sv */
// Self-checking bench of the core driven by the master-side model.
// Assumes TICKS_PER_MS of 10, so one ms is ten cycles.
`timescale 1ns/1ps
`default_nettype none
`include "mbcfg_defines.svh"
module mbcfg_core_bench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  sw = 5'h15;
  logic        fr = 1'b0;
  logic [7:0]  st = 8'h15;
  logic        qv, qd, pv, px, two, sev, asc, led, ra;
  logic [7:0]  qs, qf;
  logic [15:0] qa, qw, pd, ost, oled;
  logic [19:0] baud;
  logic [2:0]  par;
  logic [19:0] rate [8] = '{20'h00960, 20'h012c0, 20'h02580, 20'h04b00,
                            20'h09600, 20'h0e100, 20'h1c200, 20'h00046};
  int          errors = 0;
  int          check_count = 0;
  int          ticks = 0;
  always #4 mclk = ~mclk;
  mbcfg_core #(.TICKS_PER_MS(10)) dut_u (.mclk(mclk), .rst(rst),
    .addr_switch_weight1(sw[0]), .addr_switch_weight2(sw[1]),
    .addr_switch_weight4(sw[2]), .addr_switch_weight8(sw[3]),
    .addr_switch_weight16(sw[4]), .factory_restore_switch(fr),
    .req_valid(qv), .req_station(qs), .req_func(qf), .req_addr(qa),
    .req_wdata(qw), .reply_done(qd), .reply_valid(pv),
    .reply_exception(px), .reply_data(pd), .link_baud_rate(baud),
    .link_parity(par), .link_two_stop(two), .link_seven_bits(sev),
    .link_ascii(asc), .out_state(ost), .out_led(oled), .comm_led(led),
    .restore_active(ra));
  mbcfg_master m_u (.mclk(mclk), .req_valid(qv), .req_station(qs),
    .req_func(qf), .req_addr(qa), .req_wdata(qw), .reply_done(qd),
    .reply_valid(pv), .reply_exception(px), .reply_data(pd));
  task automatic chk(input string n, input logic [19:0] e,
                     input logic [19:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rq(input logic [7:0] f, input logic [15:0] a,
                    input logic [15:0] w);
    m_u.xfer({st, f, a, w});
  endtask
  task automatic test_done;
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset;
    chk("baud", 20'h04b00, baud);
    chk("line", 20'h0, 20'({par, two, sev, asc}));
    rq(`MBCFG_F_RD_HOLD, `MBCFG_OFS_TIMEOUT, 16'h0);
    chk("timeout", 20'h0, 20'(m_u.rd));
    chk("comm", 20'h1, 20'(led));
  endtask
  task automatic t_addr;
    rq(`MBCFG_F_RD_INREG, `MBCFG_OFS_SWITCH, 16'h0);
    chk("switches", 20'h00015, 20'(m_u.rd));
    st = 8'h16;
    rq(`MBCFG_F_RD_HOLD, `MBCFG_OFS_BAUD, 16'h0);
    chk("foreign", 20'h0, 20'(m_u.got));
    st = 8'h15;
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_STATION, 16'h0100);
    chk("exc", 20'h1, 20'(m_u.exc));
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_STATION, 16'h00c8);
    st = 8'hc8;
    rq(8'h07, 16'h0, 16'h0);
    chk("func", 20'h3, 20'({m_u.got, m_u.exc}));
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_STATION, 16'h0);
    st = 8'h15;
  endtask
  task automatic t_link;
    for (int i = 0; i < 8; i++) begin
      rq(`MBCFG_F_WR_REG, `MBCFG_OFS_BAUD, 16'(i));
      chk("baud", rate[i], baud);
    end
    for (int i = 0; i < 5; i++) begin
      rq(`MBCFG_F_WR_REG, `MBCFG_OFS_PARITY, 16'(i));
      chk("parity", 20'(i), 20'(par));
    end
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_FRAMING, 16'h0702);
    chk("frame", 20'h3, 20'({two, sev}));
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_MODE, 16'h0001);
    chk("ascii", 20'h1, 20'(asc));
  endtask
  task automatic t_delay;
    m_u.lag = 6;
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_DELAY, 16'h0002);
    chk("undelayed", 20'h1, 20'(m_u.cyc));
    rq(`MBCFG_F_RD_HOLD, `MBCFG_OFS_DELAY, 16'h0);
    chk("delayed", 20'h1, 20'(m_u.cyc >= 20 && m_u.cyc <= 32));
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_DELAY, 16'h0);
    m_u.lag = 0;
  endtask
  task automatic t_wdog;
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_DEFOUT, 16'h00a5);
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_OUTPUTS, 16'h3c3c);
    rq(`MBCFG_F_WR_COIL, 16'h0330, 16'h0001);
    chk("outputs", 20'h03c3d, 20'(ost));
    chk("leds", 20'h03c3d, 20'(oled));
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_TIMEOUT, 16'h0003);
    repeat (15) @(posedge mclk) #1;
    chk("held", 20'h03c3d, 20'(ost));
    rq(`MBCFG_F_RD_HOLD, `MBCFG_OFS_OUTPUTS, 16'h0);
    repeat (15) @(posedge mclk) #1;
    chk("restart", 20'h03c3d, 20'(ost));
    repeat (30) @(posedge mclk) #1;
    chk("fired", 20'h000a5, 20'(ost));
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_TIMEOUT, 16'h0);
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_OUTPUTS, 16'h1234);
    repeat (100) @(posedge mclk) #1;
    chk("off", 20'h01234, 20'(ost));
    rq(`MBCFG_F_RD_COILS, 16'h0332, 16'h0);
    chk("coil", 20'h1, 20'(m_u.rd));
    rq(`MBCFG_F_WR_COILS, 16'h00c1, 16'h0001);
    rq(`MBCFG_F_RD_COILS, 16'h00c1, 16'h0);
    chk("defcoil", 20'h1, 20'(m_u.rd));
    rq(`MBCFG_F_RD_DISC, 16'h0000, 16'h0);
    chk("disc", 20'h1, 20'(m_u.rd));
    rq(`MBCFG_F_WR_REGS, `MBCFG_OFS_DEFOUT, 16'h00ff);
    rq(`MBCFG_F_RD_HOLD, `MBCFG_OFS_DEFOUT, 16'h0);
    chk("defout", 20'h000ff, 20'(m_u.rd));
  endtask
  task automatic t_restore;
    fr = 1'b1;
    rst = 1'b1;
    repeat (20) @(posedge mclk) #1;
    rst = 1'b0;
    repeat (3) @(posedge mclk) #1;
    chk("restoring", 20'h3, 20'({ra, led}));
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_BAUD, 16'h0006);
    chk("kept", 20'h04b00, baud);
    fr = 1'b0;
    rq(`MBCFG_F_WR_REG, `MBCFG_OFS_BAUD, 16'h0006);
    chk("free", 20'h1c200, baud);
  endtask
  initial begin
    repeat (20) @(posedge mclk) #1;
    rst = 1'b0;
    t_reset;
    t_addr;
    t_link;
    t_delay;
    t_wdog;
    t_restore;
    test_done;
  end
  always @(posedge mclk) begin
    ticks++;
    if (ticks == 20000) begin
      errors++;
      test_done;
    end
  end
endmodule
`default_nettype wire
